// ---- verilog/dual_adc_sequencer.sv ----
// Conversion sequencer and result readout for a dual simultaneous-sampling converter
`timescale 1ns/1ps
// Contract
// - Busy lasts at most 1.75/2 us outside master read-after-convert.
// - Both channel conversions finish within 1.75/2 us of the start pulse.
// - End strobe stays high for channel A at most 1/1.25 us.
// - End strobe stays low at least 45 ns between channel A and B.
// - End strobe stays high for channel B at most 0.75 us.
// - Parallel result data valid within 1.75/2 us of start falling.
// - Parallel result valid at least 14 ns before busy falls.
// - Read-during-convert frame marker rises about 250/500 ns after start.
// - Read-after-convert serial clock period at least 25/50/100/200 ns per divider.
// - Read-after-convert serial clock period at most 40/70/140/280 ns per divider.
// - First serial clock edge at least 3 ns, else 17 ns, after frame marker.
// - Normal read-after-convert busy at most 3.25/4.25/6.25/10.75 us.
// - Low-power read-after-convert busy at most 3.5/4.5/6.5/11 us.
// - Read-after-convert frame marker rises about 0.75/1 us after start.
// - Busy falls about 25 ns after the frame marker falls.
// - Serial pins driven within 10 ns of chip select falling.
// - Serial pins released within 10 ns of chip select rising.
// - Serial order select high sends A then B, low sends B then A.
// - Pair select low converts first input pair, high the second.
module dual_adc_sequencer
	import adc_seq_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                CLK_I,
	input  wire logic                SYS_RST_I,
	input  wire logic                CE_I,
	// Conversion control
	input  wire logic                CONVERT_START_N_I,
	input  wire logic                LOW_POWER_I,
	input  wire logic                INPUT_PAIR_SELECT_I,
	// Sampled analog core values
	input  wire logic [RES_W-1:0]    PAIR1_A_I,
	input  wire logic [RES_W-1:0]    PAIR1_B_I,
	input  wire logic [RES_W-1:0]    PAIR2_A_I,
	input  wire logic [RES_W-1:0]    PAIR2_B_I,
	// Readout configuration
	input  wire logic                SERIAL_MODE_I,
	input  wire logic                READ_AFTER_CONVERT_I,
	input  wire logic [1:0]          SERIAL_CLOCK_DIVIDER_I,
	input  wire logic                CHANNEL_ORDER_I,
	input  wire logic                CHIP_SELECT_N_I,
	input  wire logic                SERIAL_CHAIN_IN_I,
	input  wire logic                RESULT_HOLD_I,
	// Status
	output logic                     BUSY_O,
	output logic                     END_OF_CHANNEL_O,
	output logic                     START_READY_O,
	// Parallel results
	output logic [RES_W-1:0]         RESULT_A_O,
	output logic [RES_W-1:0]         RESULT_B_O,
	// Master serial pins
	output logic                     SERIAL_CLOCK_O,
	output logic                     SERIAL_CLOCK_OE_O,
	output logic                     FRAME_MARKER_O,
	output logic                     FRAME_MARKER_OE_O,
	output logic                     SERIAL_RESULT_OUT_O,
	output logic                     SERIAL_RESULT_OUT_OE_O
);
	import adc_seq_pkg::*;

	// Start edge detection and conversion state
	logic                start_n_q;
	conv_state_t         conv_state;
	conv_state_t         next_conv_state;
	timer_t              conv_timer;
	timer_t              since_start;
	logic                mode_lp;
	logic                mode_serial;
	logic                mode_rac;
	logic                sync_pending;
	logic [RES_W-1:0]    held_a;
	logic [RES_W-1:0]    held_b;

	// Serial engine state
	ser_state_t          ser_state;
	ser_state_t          next_ser_state;
	timer_t              ser_timer;
	phase_t              ser_phase;
	phase_t              next_ser_phase;
	bitcnt_t             bits_sent;
	logic [1:0]          div_q;
	logic [PAIR_W-1:0]   shift_reg;
	logic                result_fresh;

	// Streams around the result FIFO
	result_stream_if #(.W(PAIR_W)) push_s ();
	result_stream_if #(.W(PAIR_W)) pop_s ();

	result_fifo #(
		.WIDTH (PAIR_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i (CLK_I),
		.rst_i (SYS_RST_I),
		.ce_i  (CE_I),
		.in_s  (push_s),
		.out_s (pop_s)
	);

	// Start acceptance: refused while busy or when the FIFO has no room
	wire start_fall = start_n_q & ~CONVERT_START_N_I;
	wire ser_busy   = mode_rac & mode_serial & (ser_state != SR_IDLE);
	wire busy_now   = (conv_state != CV_IDLE) | ser_busy;
	wire accept     = start_fall & ~busy_now & push_s.ready;
	assign START_READY_O = ~busy_now & push_s.ready;

	// Phase lengths for the current power mode
	wire timer_t a_budget  = mode_lp ? A_CYC_LP : A_CYC_NORM;
	wire timer_t a_cap     = mode_lp ? A_CAP_LP : A_CAP_NORM;
	wire timer_t a_len     = (a_budget < a_cap) ? a_budget : a_cap;
	wire timer_t phase_len = (conv_state == CV_A)   ? a_len :
	                         (conv_state == CV_GAP) ? GAP_CYC :
	                         (conv_state == CV_B)   ? B_CYC :
	                         SETTLE_CYC;
	wire phase_done = (conv_timer == timer_t'(phase_len - 1'b1));

	// Conversion sequence: A, gap, B, settle; total fits the budget
	always_comb begin
		next_conv_state = conv_state;
		unique case (conv_state)
			CV_IDLE:   if (accept) next_conv_state = CV_A;
			CV_A:      if (phase_done) next_conv_state = CV_GAP;
			CV_GAP:    if (phase_done) next_conv_state = CV_B;
			CV_B:      if (phase_done) next_conv_state = CV_SETTLE;
			CV_SETTLE: if (phase_done) next_conv_state = CV_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			start_n_q  <= 1'b1;
			conv_state <= CV_IDLE;
			conv_timer <= '0;
		end else if (CE_I) begin
			start_n_q  <= CONVERT_START_N_I;
			conv_state <= next_conv_state;
			conv_timer <= (next_conv_state != conv_state) ? '0 : conv_timer + 1'b1;
		end
	end

	// Sample hold and mode capture at an accepted start
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			held_a      <= '0;
			held_b      <= '0;
			mode_lp     <= 1'b0;
			mode_serial <= 1'b0;
			mode_rac    <= 1'b0;
		end else if (CE_I && accept) begin
			held_a      <= INPUT_PAIR_SELECT_I ? PAIR2_A_I : PAIR1_A_I;
			held_b      <= INPUT_PAIR_SELECT_I ? PAIR2_B_I : PAIR1_B_I;
			mode_lp     <= LOW_POWER_I;
			mode_serial <= SERIAL_MODE_I;
			mode_rac    <= READ_AFTER_CONVERT_I;
		end
	end

	// Cycles since the start edge, saturating; arms one frame per start
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			since_start  <= '0;
			sync_pending <= 1'b0;
		end else if (CE_I) begin
			if (accept) since_start <= 8'h01;
			else if (since_start != 8'hFF) since_start <= since_start + 1'b1;
			if (accept) sync_pending <= SERIAL_MODE_I;
			else if (ser_state == SR_IDLE && next_ser_state == SR_WAIT) sync_pending <= 1'b0;
		end
	end

	// Push the finished pair as channel B ends
	assign push_s.valid = (conv_state == CV_B) & phase_done;
	assign push_s.data  = {held_a, held_b};
	// Host hold stalls the drain so the FIFO can really fill
	assign pop_s.ready  = ~RESULT_HOLD_I;
	wire result_load    = pop_s.valid & pop_s.ready;

	// Parallel results: previous pair stays until the next one lands
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			RESULT_A_O <= '0;
			RESULT_B_O <= '0;
		end else if (CE_I && result_load) begin
			RESULT_A_O <= pop_s.data[PAIR_W-1:RES_W];
			RESULT_B_O <= pop_s.data[RES_W-1:0];
		end
	end

	// Fresh flag for read-after-convert; a new load wins over consumption
	wire fresh_take = (ser_state == SR_WAIT) & (next_ser_state == SR_SHIFT);
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) result_fresh <= 1'b0;
		else if (CE_I) begin
			if (result_load) result_fresh <= 1'b1;
			// A start drops an unsent older pair so a frame never ships stale data
			else if (fresh_take || accept) result_fresh <= 1'b0;
		end
	end

	// Serial timing selection
	wire timer_t sync_cyc  = mode_rac ? (mode_lp ? SYNC_RAC_LP_CYC : SYNC_RAC_NORM_CYC)
	                                  : (mode_lp ? SYNC_RDC_LP_CYC : SYNC_RDC_NORM_CYC);
	wire timer_t first_cyc = (div_q == 2'h0) ? FIRST_FAST_CYC : FIRST_SLOW_CYC;
	wire phase_t per_cyc   = SCLK_PER_CYC[div_q];
	wire phase_t low_cyc   = per_cyc >> 1;
	wire phase_end         = (ser_phase == phase_t'(per_cyc - 1'b1));
	wire last_bit          = (bits_sent == bitcnt_t'(BITS_PER_FRAME - 1'b1));
	wire wait_done         = (ser_timer >= timer_t'(first_cyc - 1'b1));
	// Read-after-convert waits for this conversion's pair
	wire data_ready        = ~mode_rac | result_fresh;

	// Serial frame sequence
	always_comb begin
		next_ser_state = ser_state;
		next_ser_phase = '0;
		unique case (ser_state)
			SR_IDLE:
				if (sync_pending && since_start >= sync_cyc) next_ser_state = SR_WAIT;
			SR_WAIT:
				if (wait_done && data_ready) next_ser_state = SR_SHIFT;
			SR_SHIFT: begin
				next_ser_phase = phase_end ? '0 : ser_phase + 1'b1;
				if (phase_end && last_bit) next_ser_state = SR_TAIL;
			end
			SR_TAIL:
				if (ser_timer == timer_t'(TAIL_CYC - 1'b1)) next_ser_state = SR_IDLE;
		endcase
	end

	// Serial control registers
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			ser_state <= SR_IDLE;
			ser_timer <= '0;
			ser_phase <= '0;
			bits_sent <= '0;
			div_q     <= 2'h0;
		end else if (CE_I) begin
			ser_state <= next_ser_state;
			ser_timer <= (next_ser_state != ser_state) ? '0 : ser_timer + 1'b1;
			ser_phase <= next_ser_phase;
			if (ser_state == SR_IDLE) div_q <= SERIAL_CLOCK_DIVIDER_I;
			if (ser_state != SR_SHIFT) bits_sent <= '0;
			else if (phase_end) bits_sent <= bits_sent + 1'b1;
		end
	end

	// Shift register: loaded as clocking begins, MSB first
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) shift_reg <= '0;
		else if (CE_I) begin
			if (fresh_take)
				shift_reg <= CHANNEL_ORDER_I ? {RESULT_A_O, RESULT_B_O}
				                             : {RESULT_B_O, RESULT_A_O};
			else if (ser_state == SR_SHIFT && phase_end)
				shift_reg <= {shift_reg[PAIR_W-2:0], SERIAL_CHAIN_IN_I};
		end
	end

	// Pin levels, registered; clock low first, data moves on falling edge
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			SERIAL_CLOCK_O   <= 1'b0;
			FRAME_MARKER_O   <= 1'b0;
			BUSY_O           <= 1'b0;
			END_OF_CHANNEL_O <= 1'b0;
		end else if (CE_I) begin
			SERIAL_CLOCK_O   <= (next_ser_state == SR_SHIFT) && (next_ser_phase >= low_cyc);
			FRAME_MARKER_O   <= (next_ser_state == SR_WAIT) || (next_ser_state == SR_SHIFT);
			END_OF_CHANNEL_O <= (next_conv_state == CV_A) || (next_conv_state == CV_B);
			// Busy covers the conversion, and in read-after-convert the frame and tail
			BUSY_O <= (next_conv_state != CV_IDLE) ||
			          (mode_rac && mode_serial && next_ser_state != SR_IDLE);
		end
	end
	assign SERIAL_RESULT_OUT_O = shift_reg[PAIR_W-1];

	// Serial pins follow chip select with no clock delay
	wire serial_drive        = SERIAL_MODE_I & ~CHIP_SELECT_N_I;
	assign SERIAL_CLOCK_OE_O      = serial_drive;
	assign FRAME_MARKER_OE_O      = serial_drive;
	assign SERIAL_RESULT_OUT_OE_O = serial_drive;
endmodule

// ---- verilog/adc_seq_pkg.sv ----
// Shared constants, timing counts and state types for the conversion sequencer
package adc_seq_pkg;
	// Clock and data widths
	localparam int CLK_PERIOD_NS = 10;
	localparam int RES_W         = 16;
	localparam int PAIR_W        = 2 * RES_W;
	localparam int FIFO_DEPTH    = 16;
	localparam int TIMER_W       = 8;
	localparam int PHASE_W       = 5;
	localparam int BIT_CNT_W     = 6;

	typedef logic [TIMER_W-1:0]   timer_t;
	typedef logic [PHASE_W-1:0]   phase_t;
	typedef logic [BIT_CNT_W-1:0] bitcnt_t;

	// Least times round up, never below one cycle
	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest times round down, never below one cycle
	function automatic int floor_cycles(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Times as specified, in ns
	localparam int CONV_MAX_NORM_NS    = 1750;
	localparam int CONV_MAX_LP_NS      = 2000;
	localparam int EOC_A_MAX_NORM_NS   = 1000;
	localparam int EOC_A_MAX_LP_NS     = 1250;
	localparam int EOC_GAP_MIN_NS      = 45;
	localparam int EOC_B_MAX_NS        = 750;
	localparam int DATA_TO_BUSY_MIN_NS = 14;
	localparam int SYNC_RDC_NORM_NS    = 250;
	localparam int SYNC_RDC_LP_NS      = 500;
	localparam int SYNC_RAC_NORM_NS    = 750;
	localparam int SYNC_RAC_LP_NS      = 1000;
	localparam int SYNC_TO_BUSY_NS     = 25;
	localparam int FIRST_EDGE_FAST_NS  = 3;
	localparam int FIRST_EDGE_SLOW_NS  = 17;
	localparam int SCLK_MIN_NS [4]     = '{25, 50, 100, 200};
	localparam int SCLK_MAX_NS [4]     = '{40, 70, 140, 280};

	// Cycles from a pushed result to the parallel result registers
	localparam int RESULT_PIPE_CYC = 3;

	// Derived phase lengths in cycles
	localparam int GAP_I    = ceil_cycles(EOC_GAP_MIN_NS);
	localparam int B_I      = floor_cycles(EOC_B_MAX_NS);
	localparam int SETTLE_I = ceil_cycles(DATA_TO_BUSY_MIN_NS) + RESULT_PIPE_CYC;
	localparam timer_t GAP_CYC    = timer_t'(GAP_I);
	localparam timer_t B_CYC      = timer_t'(B_I);
	localparam timer_t SETTLE_CYC = timer_t'(SETTLE_I);
	// Channel A takes what is left of the conversion budget
	localparam timer_t A_CYC_NORM =
		timer_t'(floor_cycles(CONV_MAX_NORM_NS) - GAP_I - B_I - SETTLE_I);
	localparam timer_t A_CYC_LP   =
		timer_t'(floor_cycles(CONV_MAX_LP_NS) - GAP_I - B_I - SETTLE_I);
	localparam timer_t A_CAP_NORM = timer_t'(floor_cycles(EOC_A_MAX_NORM_NS));
	localparam timer_t A_CAP_LP   = timer_t'(floor_cycles(EOC_A_MAX_LP_NS));
	localparam timer_t SYNC_RDC_NORM_CYC = timer_t'(ceil_cycles(SYNC_RDC_NORM_NS));
	localparam timer_t SYNC_RDC_LP_CYC   = timer_t'(ceil_cycles(SYNC_RDC_LP_NS));
	localparam timer_t SYNC_RAC_NORM_CYC = timer_t'(ceil_cycles(SYNC_RAC_NORM_NS));
	localparam timer_t SYNC_RAC_LP_CYC   = timer_t'(ceil_cycles(SYNC_RAC_LP_NS));
	localparam timer_t TAIL_CYC          = timer_t'(ceil_cycles(SYNC_TO_BUSY_NS));
	localparam timer_t FIRST_FAST_CYC    = timer_t'(ceil_cycles(FIRST_EDGE_FAST_NS));
	localparam timer_t FIRST_SLOW_CYC    = timer_t'(ceil_cycles(FIRST_EDGE_SLOW_NS));
	// Serial clock period per divider code: least period rounded up
	localparam phase_t SCLK_PER_CYC [4] = '{
		phase_t'(ceil_cycles(SCLK_MIN_NS[0])), phase_t'(ceil_cycles(SCLK_MIN_NS[1])),
		phase_t'(ceil_cycles(SCLK_MIN_NS[2])), phase_t'(ceil_cycles(SCLK_MIN_NS[3]))};
	localparam bitcnt_t BITS_PER_FRAME = bitcnt_t'(PAIR_W);

	typedef enum {CV_IDLE, CV_A, CV_GAP, CV_B, CV_SETTLE} conv_state_t;
	typedef enum {SR_IDLE, SR_WAIT, SR_SHIFT, SR_TAIL} ser_state_t;
endpackage

// ---- verilog/result_stream_if.sv ----
// Valid/ready stream carrying result pairs between the sequencer and its FIFO
`timescale 1ns/1ps
interface result_stream_if #(parameter int W = 32);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport tx (output valid, output data, input ready);
	modport rx (input valid, input data, output ready);
endinterface

// ---- verilog/result_fifo.sv ----
// Result FIFO with registered read data and honest full/empty
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock, reset, enable
	input  wire logic    clk_i,
	input  wire logic    rst_i,
	input  wire logic    ce_i,
	// Streams
	result_stream_if.rx  in_s,
	result_stream_if.tx  out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;
	logic             out_valid;
	logic [WIDTH-1:0] out_data;

	// Handshake decode
	wire push      = in_s.valid & in_s.ready;
	wire out_free  = ~out_valid | out_s.ready;
	wire pop       = out_free & (count != '0);
	assign in_s.ready  = (count != FULL_CNT);
	assign out_s.valid = out_valid;
	assign out_s.data  = out_data;

	// Storage array, no reset needed
	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem[wptr] <= in_s.data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else if (ce_i) begin
			if (push) wptr <= wptr + 1'b1;
			if (pop) rptr <= rptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Read register: holds head word until drained
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce_i && out_free) begin
			out_valid <= pop;
			if (pop) out_data <= mem[rptr];
		end
	end
endmodule

// ---- testbench/dual_adc_sequencer_assertions.sv ----
// Port-level timing checks for the dual converter sequencer
`timescale 1ns/1ps
module dual_adc_sequencer_checker (
	// Clock and reset
	input wire logic       CLK_I,
	input wire logic       SYS_RST_I,
	// Controls
	input wire logic       CE_I,
	input wire logic       CONVERT_START_N_I,
	input wire logic       LOW_POWER_I,
	input wire logic       SERIAL_MODE_I,
	input wire logic       READ_AFTER_CONVERT_I,
	input wire logic [1:0] SERIAL_CLOCK_DIVIDER_I,
	input wire logic       CHIP_SELECT_N_I,
	// Status and serial pins
	input wire logic       BUSY_O,
	input wire logic       END_OF_CHANNEL_O,
	input wire logic       START_READY_O,
	input wire logic       SERIAL_CLOCK_O,
	input wire logic       SERIAL_CLOCK_OE_O,
	input wire logic       FRAME_MARKER_O,
	input wire logic       FRAME_MARKER_OE_O,
	input wire logic       SERIAL_RESULT_OUT_OE_O
);
	localparam int PLO [4] = '{3, 5, 10, 20};
	localparam int PHI [4] = '{4, 7, 14, 28};
	localparam int BN  [4] = '{325, 425, 625, 1075};
	localparam int BL  [4] = '{350, 450, 650, 1100};
	localparam int MK  [4] = '{25, 50, 75, 100};
	logic        prev_n, lp, rac, in_b, sclk_q, seen;
	logic [1:0]  dv;
	logic [10:0] since, eoc_cnt;
	logic [4:0]  per;
	wire         acc = CE_I & START_READY_O & prev_n & ~CONVERT_START_N_I;
	wire         sclk_rise = SERIAL_CLOCK_O & ~sclk_q;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// Mode captured at each accepted start, since the limits follow it
	always_ff @(posedge CLK_I) begin
		prev_n  <= CONVERT_START_N_I;
		sclk_q  <= SERIAL_CLOCK_O;
		since   <= acc ? 11'h001 : (BUSY_O ? since + 11'h001 : 11'h000);
		eoc_cnt <= END_OF_CHANNEL_O ? eoc_cnt + 11'h001 : 11'h000;
		per     <= sclk_rise ? 5'h01 : per + 5'h01;
		seen    <= FRAME_MARKER_O & (seen | sclk_rise);
		in_b    <= (acc | SYS_RST_I) ? 1'b0 : in_b | ((|eoc_cnt) & ~END_OF_CHANNEL_O);
		if (acc) begin
			lp  <= LOW_POWER_I;
			rac <= READ_AFTER_CONVERT_I & SERIAL_MODE_I;
			dv  <= SERIAL_CLOCK_DIVIDER_I;
		end
	end
	a_conv_within: assert property (
		END_OF_CHANNEL_O |-> since <= (lp ? 200 : 175)) else $error("conversion too long");
	a_busy_limit: assert property (
		BUSY_O && !rac |-> since <= (lp ? 200 : 175)) else $error("busy too long");
	a_rac_busy_limit: assert property (
		BUSY_O && rac |-> since <= (lp ? BL[dv] : BN[dv])) else $error("serial busy too long");
	a_eoc_a_width: assert property (
		END_OF_CHANNEL_O && !in_b |-> eoc_cnt < (lp ? 125 : 100)) else $error("strobe A too long");
	a_eoc_gap_width: assert property (
		$fell(END_OF_CHANNEL_O) && BUSY_O && !in_b |-> !END_OF_CHANNEL_O [*5])
		else $error("strobe gap too short");
	a_eoc_b_width: assert property (
		END_OF_CHANNEL_O && in_b |-> eoc_cnt < 75) else $error("strobe B too long");
	a_marker_delay: assert property (
		$rose(FRAME_MARKER_O) |-> since >= MK[{rac, lp}] && since <= MK[{rac, lp}] + 3)
		else $error("frame marker mistimed");
	a_first_edge_gap: assert property (
		$rose(FRAME_MARKER_O) |-> !SERIAL_CLOCK_O ##1 (dv == 2'h0 || !SERIAL_CLOCK_O))
		else $error("first clock edge too early");
	a_sclk_period: assert property (
		sclk_rise && seen && rac |-> per >= PLO[dv] && per <= PHI[dv])
		else $error("serial clock period out of range");
	a_busy_tail: assert property (
		$fell(FRAME_MARKER_O) && rac |-> BUSY_O ##[1:3] !BUSY_O) else $error("busy tail wrong");
	a_pin_enables: assert property (
		SERIAL_CLOCK_OE_O == (SERIAL_MODE_I & ~CHIP_SELECT_N_I) &&
		FRAME_MARKER_OE_O == SERIAL_CLOCK_OE_O && SERIAL_RESULT_OUT_OE_O == SERIAL_CLOCK_OE_O)
		else $error("pin enable wrong");
endmodule

// ---- testbench/host_result_reader.sv ----
// Host model that captures master serial result frames
`timescale 1ns/1ps
module host_result_reader (
	// Clock and serial pins
	input  wire logic                        clk_i,
	input  wire logic                        sclk_i,
	input  wire logic                        sclk_oe_i,
	input  wire logic                        mark_i,
	input  wire logic                        sdo_i,
	input  wire logic                        sdo_oe_i,
	// Captured frames
	output logic [adc_seq_pkg::PAIR_W-1:0]   word_o,
	output logic [7:0]                       frames_o
);
	import adc_seq_pkg::*;
	logic              sclk_q = 1'b0;
	logic              mark_q = 1'b0;
	logic              last_bit = 1'b0;
	logic [PAIR_W-1:0] shift = '0;
	logic [PAIR_W-1:0] word = '0;
	logic [7:0]        frames = 8'h00;
	// Clock and marker lines pulled low when released; data line floats
	wire               sclk_line = sclk_oe_i & sclk_i;
	wire               mark_line = sclk_oe_i & mark_i;
	wire               sdo_line  = sdo_oe_i ? sdo_i : ~last_bit;
	assign word_o   = word;
	assign frames_o = frames;
	// Sample on rising clock, first bit lands at the top; whole frame at marker fall
	always @(posedge clk_i) begin
		sclk_q <= sclk_line;
		mark_q <= mark_line;
		last_bit <= sdo_line;
		if (mark_line & sclk_line & ~sclk_q) begin
			shift <= {shift[PAIR_W-2:0], sdo_line};
		end
		if (mark_q & ~mark_line) begin
			word <= shift;
			frames <= frames + 8'h01;
		end
	end
endmodule

// ---- testbench/test_dual_adc_sequencer.sv ----
// Self-checking bench for the dual converter sequencer
`timescale 1ns/1ps
module test_dual_adc_sequencer;
	import adc_seq_pkg::*;
	logic              CLK_I = 1'b0, SYS_RST_I = 1'b1, CE_I = 1'b1, CONVERT_START_N_I = 1'b1;
	logic              LOW_POWER_I = 1'b0, INPUT_PAIR_SELECT_I = 1'b0, SERIAL_MODE_I = 1'b0;
	logic              READ_AFTER_CONVERT_I = 1'b0, CHANNEL_ORDER_I = 1'b1;
	logic              CHIP_SELECT_N_I = 1'b0, SERIAL_CHAIN_IN_I = 1'b0, RESULT_HOLD_I = 1'b0;
	logic [1:0]        SERIAL_CLOCK_DIVIDER_I = 2'h0;
	logic [RES_W-1:0]  PAIR1_A_I = 16'h0000, PAIR1_B_I = 16'h0000;
	logic [RES_W-1:0]  PAIR2_A_I = 16'h0000, PAIR2_B_I = 16'h0000;
	logic              BUSY_O, END_OF_CHANNEL_O, START_READY_O, SERIAL_CLOCK_O;
	logic              SERIAL_CLOCK_OE_O, FRAME_MARKER_O, FRAME_MARKER_OE_O;
	logic              SERIAL_RESULT_OUT_O, SERIAL_RESULT_OUT_OE_O;
	logic [RES_W-1:0]  RESULT_A_O, RESULT_B_O;
	logic [PAIR_W-1:0] host_word, exp_pair = '0, snap;
	logic [7:0]        host_frames, seq = 8'h00;
	int                err_total = 0, comparisons = 0, busy_len = 0;
	int                busy_norm [4] = '{325, 425, 625, 1075};
	int                busy_lp [4] = '{350, 450, 650, 1100};
	always #5 CLK_I = ~CLK_I;
	dual_adc_sequencer dut (.*);
	host_result_reader host (
		.clk_i     (CLK_I),
		.sclk_i    (SERIAL_CLOCK_O),
		.sclk_oe_i (SERIAL_CLOCK_OE_O),
		.mark_i    (FRAME_MARKER_O),
		.sdo_i     (SERIAL_RESULT_OUT_O),
		.sdo_oe_i  (SERIAL_RESULT_OUT_OE_O),
		.word_o    (host_word),
		.frames_o  (host_frames)
	);
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_lim(input int got, input int lim);
		comparisons++;
		if (got > lim) begin
			err_total++;
			$display("wrong value at %0t: %0d cycles above %0d", $time, got, lim);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One conversion on fresh core values; a nonzero poke retries the start mid-busy
	task automatic convert(input logic sel, input logic lp, input int poke);
		int n;
		n = 0;
		while (BUSY_O !== 1'b0 && n < 2000) begin
			@(negedge CLK_I);
			n++;
		end
		repeat (60) @(negedge CLK_I); // start spacing kept by the host
		seq++;
		PAIR1_A_I = {8'h1A, seq};
		PAIR1_B_I = {8'h1B, seq};
		PAIR2_A_I = {8'h2A, seq};
		PAIR2_B_I = {8'h2B, seq};
		INPUT_PAIR_SELECT_I = sel;
		LOW_POWER_I = lp;
		CONVERT_START_N_I = 1'b0;
		repeat (2) @(negedge CLK_I);
		CONVERT_START_N_I = 1'b1;
		busy_len = 1;
		while (BUSY_O === 1'b1 && busy_len < 2000) begin
			if (busy_len == poke) begin
				chk_word({RESULT_A_O, RESULT_B_O}, exp_pair);
				INPUT_PAIR_SELECT_I = ~sel;
				CONVERT_START_N_I = 1'b0;
			end
			if (busy_len == poke + 2)
				CONVERT_START_N_I = 1'b1;
			snap = {RESULT_A_O, RESULT_B_O};
			@(negedge CLK_I);
			busy_len++;
		end
		exp_pair = sel ? {PAIR2_A_I, PAIR2_B_I} : {PAIR1_A_I, PAIR1_B_I};
	endtask
	// Both input pairs in both power modes, parallel readout
	task automatic t_parallel();
		for (int i = 0; i < 4; i++) begin
			convert(i[0], i[1], 0);
			chk_lim(busy_len, i[1] ? 200 : 175);
			chk_word(snap, exp_pair);
		end
	endtask
	// A start during busy is dropped, nothing follows the first conversion
	task automatic t_ignore();
		convert(1'b0, 1'b0, 50);
		chk_word(snap, exp_pair);
		repeat (3) @(negedge CLK_I);
		chk_word({31'h0, BUSY_O}, 32'h0);
	endtask
	// Read-after-convert frames for every divider code and both orders
	task automatic t_serial_rac();
		SERIAL_MODE_I = 1'b1;
		READ_AFTER_CONVERT_I = 1'b1;
		for (int d = 0; d < 4; d++) begin
			SERIAL_CLOCK_DIVIDER_I = 2'(d);
			CHANNEL_ORDER_I = d[0];
			convert(d[1], d[1], 0);
			chk_lim(busy_len, d[1] ? busy_lp[d] : busy_norm[d]);
			chk_word(host_word, d[0] ? exp_pair : {exp_pair[15:0], exp_pair[31:16]});
		end
	endtask
	// Read-during-convert sends the previous pair; chip select gates the pins
	task automatic t_serial_rdc();
		logic [PAIR_W-1:0] prev;
		logic [7:0]        frames;
		READ_AFTER_CONVERT_I = 1'b0;
		SERIAL_CLOCK_DIVIDER_I = 2'h0;
		CHANNEL_ORDER_I = 1'b1;
		prev = exp_pair;
		convert(1'b0, 1'b1, 0);
		chk_word(host_word, prev);
		CHIP_SELECT_N_I = 1'b1;
		frames = host_frames;
		convert(1'b1, 1'b0, 0);
		chk_word({24'h0, host_frames}, {24'h0, frames});
		chk_word({29'h0, SERIAL_CLOCK_OE_O, FRAME_MARKER_OE_O, SERIAL_RESULT_OUT_OE_O}, 32'h0);
		CHIP_SELECT_N_I = 1'b0;
		@(negedge CLK_I);
		chk_word({29'h0, SERIAL_CLOCK_OE_O, FRAME_MARKER_OE_O, SERIAL_RESULT_OUT_OE_O}, 32'h7);
		SERIAL_MODE_I = 1'b0;
	endtask
	// Fill the result queue while the reader stalls, then drain it
	task automatic t_fifo();
		logic [PAIR_W-1:0] held, last;
		held = {RESULT_A_O, RESULT_B_O};
		RESULT_HOLD_I = 1'b1;
		// The read register holds one pair beyond the queue depth
		repeat (FIFO_DEPTH + 1) convert(1'b1, 1'b0, 0);
		last = exp_pair;
		chk_word({RESULT_A_O, RESULT_B_O}, held);
		chk_word({31'h0, START_READY_O}, 32'h0);
		convert(1'b0, 1'b0, 0);
		chk_lim(busy_len, 1);
		RESULT_HOLD_I = 1'b0;
		repeat (200) @(negedge CLK_I);
		chk_word({RESULT_A_O, RESULT_B_O}, last);
		chk_word({31'h0, START_READY_O}, 32'h1);
	endtask
	initial begin
		repeat (3) @(negedge CLK_I);
		SYS_RST_I = 1'b0;
		repeat (3) @(negedge CLK_I);
		t_parallel();
		t_ignore();
		t_serial_rac();
		t_serial_rdc();
		t_fifo();
		end_of_test();
	end
	// Watchdog well past the expected run of about 82 us
	initial begin
		#300000;
		err_total++;
		$display("wrong value at %0t: run did not finish", $time);
		end_of_test();
	end
endmodule
bind dual_adc_sequencer dual_adc_sequencer_checker chk (.*);
